/* File: src/ct_supervision_pkg.sv */
// Package for the current transformer supervision block.
// Assumes magnitudes in 0.01 x nominal units, ratios in 0.01 percent units.
package ct_supervision_pkg;

  // ----------------------------------------------------------------
  // Formats
  // ----------------------------------------------------------------
  localparam int MAG_W = 16;
  localparam int ANG_W = 16;
  localparam int DLY_W = 19;

  // ----------------------------------------------------------------
  // Reset values of settings (0.01 steps; alarm delay in 5 ms steps)
  // ----------------------------------------------------------------
  localparam logic [MAG_W-1:0] HIGH_LIMIT_RST = 16'd120;
  localparam logic [MAG_W-1:0] LOW_LIMIT_RST = 16'd10;
  localparam logic [MAG_W-1:0] RATIO_LIMIT_RST = 16'd1000;
  localparam logic [MAG_W-1:0] UNBAL_LIMIT_RST = 16'd4900;
  localparam logic [MAG_W-1:0] SUM_LIMIT_RST = 16'd10;
  // Alarm delay in 5 ms steps: 0.5 s
  localparam logic [DLY_W-1:0] ALARM_DELAY_RST = 19'd100;

  // ----------------------------------------------------------------
  // Hysteresis, percent of threshold
  // ----------------------------------------------------------------
  localparam int REL_OVER_PCT = 97;
  localparam int REL_UNDER_PCT = 103;
  localparam int PCT_FULL = 100;
  localparam int RATIO_FULL = 10000;

  // ----------------------------------------------------------------
  // Time base
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 50_000_000;
  localparam int TICK_MS = 5;
  localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;

  // ----------------------------------------------------------------
  // Selectors
  // ----------------------------------------------------------------
  localparam logic [1:0] RES_NONE = 2'h0;
  localparam logic [1:0] RES_ONE = 2'h1;
  localparam logic [1:0] RES_TWO = 2'h2;
  localparam logic [1:0] FORCE_NORMAL = 2'h0;
  localparam logic [1:0] FORCE_ALARM = 2'h1;
  localparam logic [1:0] FORCE_BLOCKED = 2'h2;

endpackage

/* File: src/hyst_compare.sv */
// Threshold comparator with fixed release hysteresis.
// Assumes one update per measurement tick; value and limit share units.
`default_nettype none
module hyst_compare
  import ct_supervision_pkg::*;
#(
  parameter int W = MAG_W,
  parameter bit OVER = 1'b1
) (
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  input wire logic tick_i,
  input wire logic [W-1:0] value_i,
  input wire logic [W-1:0] limit_i,
  output logic hit_o
);

  logic hit_q;
  logic hit_d;
  logic [W+7:0] val_x;
  logic [W+7:0] op_x;
  logic [W+7:0] rel_x;

  // ----------------------------------------------------------------
  // Compare scaled by 100 to keep integer math exact
  // ----------------------------------------------------------------
  always_comb begin
    val_x = (W+8)'(value_i) * (W+8)'(PCT_FULL);
    op_x = (W+8)'(limit_i) * (W+8)'(PCT_FULL);
    if (OVER) begin
      rel_x = (W+8)'(limit_i) * (W+8)'(REL_OVER_PCT);
      hit_d = hit_q ? (val_x > rel_x) : (val_x > op_x);
    end else begin
      rel_x = (W+8)'(limit_i) * (W+8)'(REL_UNDER_PCT);
      hit_d = hit_q ? (val_x < rel_x) : (val_x < op_x);
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      hit_q <= 1'b0;
    end else if (tick_i) begin
      hit_q <= hit_d;
    end
  end

  assign hit_o = hit_q;

endmodule
`default_nettype wire

/* File: src/current_transformer_supervision.sv */
// Current transformer supervision: limit checks, delay, blocking, force.
// Assumes measurements are fundamental magnitudes, synchronous to ref_clk_i.
`default_nettype none

// Behaviour
// - Release at 97/103 percent of threshold
// - Compare each phase and residual against threshold
// - One limit for all phases, any phase
// - Any phase over high limit blocks activation
// - Lower current limit must be satisfied
// - Min over max ratio below ratio limit
// - Negative over positive sequence above limit
// - Residual sum difference above limit when enabled
// - Alarm after condition lasts programmed delay
// - Delay fixed, independent of magnitudes
// - Blocking sampled at each cycle start
// - Pick-up unblocked gives start, runs timer
// - Pick-up blocked gives blocked, stops processing
// - Late blocking clears start like drop-out
// - Settings change live via setting group
// - Report sum difference magnitude, 0.01 resolution
// - Report sum difference angle, 0.01 degrees
// - All conditions needed; residual only if selected
// - Residual source none, channel one, two
// - Polarity adds or subtracts residual channel
// - Forcing overrides status normal, alarm, blocked
module current_transformer_supervision
  import ct_supervision_pkg::*;
#(
  parameter int TICK_LEN = TICK_CYCLES
) (
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  input wire logic [MAG_W-1:0] phase_a_mag_i,
  input wire logic [MAG_W-1:0] phase_b_mag_i,
  input wire logic [MAG_W-1:0] phase_c_mag_i,
  input wire logic [MAG_W-1:0] residual_channel_one_i,
  input wire logic [MAG_W-1:0] residual_channel_two_i,
  input wire logic [ANG_W-1:0] residual_one_ang_i,
  input wire logic [ANG_W-1:0] residual_two_ang_i,
  input wire logic [MAG_W-1:0] phase_sum_mag_i,
  input wire logic [ANG_W-1:0] phase_sum_ang_i,
  input wire logic [MAG_W-1:0] sum_diff_add_i,
  input wire logic [MAG_W-1:0] sum_diff_sub_i,
  input wire logic [MAG_W-1:0] sequence_unbalance_ratio_i,
  input wire logic block_i,
  input wire logic [MAG_W-1:0] high_limit_i,
  input wire logic [MAG_W-1:0] phase_current_limit_i,
  input wire logic [MAG_W-1:0] ratio_limit_i,
  input wire logic [MAG_W-1:0] unbalance_limit_i,
  input wire logic [MAG_W-1:0] residual_current_limit_i,
  input wire logic [DLY_W-1:0] alarm_delay_i,
  input wire logic [1:0] residual_select_i,
  input wire logic residual_subtract_i,
  input wire logic force_enable_i,
  input wire logic [1:0] force_status_i,
  output logic start_o,
  output logic blocked_o,
  output logic alarm_o,
  output logic [MAG_W-1:0] sum_diff_mag_o,
  output logic [ANG_W-1:0] sum_diff_ang_o,
  output logic tick_o
);

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_TIMING,
    ST_ALARM,
    ST_BLOCKED
  } cts_state_t;

  localparam int TICK_W = $clog2(TICK_LEN + 1);

  cts_state_t state_q;
  cts_state_t state_d;
  logic [TICK_W-1:0] tick_cnt_q;
  logic tick_q;
  logic [DLY_W-1:0] delay_cnt_q;
  logic block_q;
  logic [MAG_W-1:0] mags [4];
  logic [MAG_W-1:0] lim_hi [4];
  logic [MAG_W-1:0] lim_lo [4];
  logic [3:0] over_hi;
  logic [3:0] over_lo;
  logic [3:0] under_lo;
  logic [MAG_W-1:0] res_mag;
  logic [ANG_W-1:0] res_ang;
  logic [MAG_W-1:0] min_mag;
  logic [MAG_W-1:0] max_mag;
  logic [MAG_W+15:0] min_scaled;
  logic [MAG_W+15:0] max_scaled;
  logic ratio_ok;
  logic unbal_ok;
  logic sum_ok;
  logic res_used;
  logic ratio_q;
  logic unbal_q;
  logic res_used_q;
  logic pickup;
  logic delay_done;

  // ----------------------------------------------------------------
  // Measurement time base
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      tick_cnt_q <= '0;
      tick_q <= 1'b0;
    end else if (tick_cnt_q == TICK_W'(TICK_LEN - 1)) begin
      tick_cnt_q <= '0;
      tick_q <= 1'b1;
    end else begin
      tick_cnt_q <= tick_cnt_q + 1'b1;
      tick_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Residual source and polarity
  // ----------------------------------------------------------------
  always_comb begin
    case (residual_select_i)
      RES_ONE: begin
        res_mag = residual_channel_one_i;
        res_ang = residual_one_ang_i;
      end
      RES_TWO: begin
        res_mag = residual_channel_two_i;
        res_ang = residual_two_ang_i;
      end
      default: begin
        res_mag = '0;
        res_ang = '0;
      end
    endcase
  end

  assign res_used = (residual_select_i == RES_ONE) || (residual_select_i == RES_TWO);

  // ----------------------------------------------------------------
  // Per-channel limit comparisons
  // ----------------------------------------------------------------
  assign mags[0] = phase_a_mag_i;
  assign mags[1] = phase_b_mag_i;
  assign mags[2] = phase_c_mag_i;
  assign mags[3] = residual_subtract_i ? sum_diff_sub_i : sum_diff_add_i;
  assign lim_hi[0] = high_limit_i;
  assign lim_hi[1] = high_limit_i;
  assign lim_hi[2] = high_limit_i;
  assign lim_hi[3] = residual_current_limit_i;
  assign lim_lo[0] = phase_current_limit_i;
  assign lim_lo[1] = phase_current_limit_i;
  assign lim_lo[2] = phase_current_limit_i;
  assign lim_lo[3] = residual_current_limit_i;

  // Slot 3 compares the residual difference; its low tests go unused
  // Each channel against its live setting
  for (genvar g = 0; g < 4; g++) begin : g_chan
    hyst_compare #(.W(MAG_W), .OVER(1'b1)) u_hi (
      .ref_clk_i(ref_clk_i),
      .rst_b_i(rst_b_i),
      .tick_i(tick_q),
      .value_i(mags[g]),
      .limit_i(lim_hi[g]),
      .hit_o(over_hi[g])
    );
    hyst_compare #(.W(MAG_W), .OVER(1'b1)) u_lo (
      .ref_clk_i(ref_clk_i),
      .rst_b_i(rst_b_i),
      .tick_i(tick_q),
      .value_i(mags[g]),
      .limit_i(lim_lo[g]),
      .hit_o(over_lo[g])
    );
    hyst_compare #(.W(MAG_W), .OVER(1'b0)) u_ul (
      .ref_clk_i(ref_clk_i),
      .rst_b_i(rst_b_i),
      .tick_i(tick_q),
      .value_i(mags[g]),
      .limit_i(lim_lo[g]),
      .hit_o(under_lo[g])
    );
  end

  // ----------------------------------------------------------------
  // Ratio conditions
  // ----------------------------------------------------------------
  always_comb begin
    min_mag = phase_a_mag_i;
    max_mag = phase_a_mag_i;
    if (phase_b_mag_i < min_mag) begin
      min_mag = phase_b_mag_i;
    end
    if (phase_c_mag_i < min_mag) begin
      min_mag = phase_c_mag_i;
    end
    if (phase_b_mag_i > max_mag) begin
      max_mag = phase_b_mag_i;
    end
    if (phase_c_mag_i > max_mag) begin
      max_mag = phase_c_mag_i;
    end
    // Cross-multiplied so no divider is needed
    min_scaled = (MAG_W+16)'(min_mag) * (MAG_W+16)'(RATIO_FULL);
    max_scaled = (MAG_W+16)'(max_mag) * (MAG_W+16)'(ratio_limit_i);
  end

  assign ratio_ok = (max_mag != '0) && (min_scaled < max_scaled);
  assign unbal_ok = sequence_unbalance_ratio_i > unbalance_limit_i;

  // ----------------------------------------------------------------
  // Live conditions held per tick
  // ----------------------------------------------------------------
  // Live ratios beside tick-old comparator hits would start falsely
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ratio_q <= 1'b0;
      unbal_q <= 1'b0;
      res_used_q <= 1'b0;
    end else if (tick_q) begin
      ratio_q <= ratio_ok;
      unbal_q <= unbal_ok;
      res_used_q <= res_used;
    end
  end

  assign sum_ok = !res_used_q || over_hi[3];

  // Sampled on tick, so comparators and pickup share one cycle
  assign pickup = !(|over_hi[2:0])
                  && (|over_lo[2:0]) && (|under_lo[2:0])
                  && ratio_q && unbal_q && sum_ok;

  assign delay_done = (delay_cnt_q >= alarm_delay_i);

  // ----------------------------------------------------------------
  // Blocking sample at each cycle start
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      block_q <= 1'b0;
    end else if (tick_q) begin
      block_q <= block_i;
    end
  end

  // ----------------------------------------------------------------
  // Status sequence
  // ----------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (pickup && block_q) begin
          state_d = ST_BLOCKED;
        end else if (pickup) begin
          state_d = ST_TIMING;
        end
      end
      ST_TIMING: begin
        if (!pickup || block_q) begin
          state_d = ST_IDLE;
        end else if (delay_done) begin
          state_d = ST_ALARM;
        end
      end
      ST_ALARM: begin
        if (!pickup || block_q) begin
          state_d = ST_IDLE;
        end
      end
      ST_BLOCKED: begin
        if (!pickup || !block_q) begin
          state_d = ST_IDLE;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  // Settings are read live, so a new group takes effect next tick
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_q <= ST_IDLE;
    end else if (tick_q) begin
      state_q <= state_d;
    end
  end

  // ----------------------------------------------------------------
  // Definite delay counter, 5 ms per count
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      delay_cnt_q <= '0;
    end else if (tick_q) begin
      if (state_d == ST_TIMING && state_q == ST_TIMING) begin
        delay_cnt_q <= delay_cnt_q + 1'b1;
      end else if (state_d == ST_TIMING) begin
        delay_cnt_q <= DLY_W'(1);
      end else if (state_d != ST_ALARM) begin
        delay_cnt_q <= '0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Outputs with forcing
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      start_o <= 1'b0;
      blocked_o <= 1'b0;
      alarm_o <= 1'b0;
    end else if (force_enable_i) begin
      start_o <= 1'b0;
      blocked_o <= (force_status_i == FORCE_BLOCKED);
      alarm_o <= (force_status_i == FORCE_ALARM);
    end else begin
      start_o <= (state_q == ST_TIMING) || (state_q == ST_ALARM);
      blocked_o <= (state_q == ST_BLOCKED);
      alarm_o <= (state_q == ST_ALARM);
    end
  end

  // ----------------------------------------------------------------
  // Difference readouts
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sum_diff_mag_o <= '0;
      sum_diff_ang_o <= '0;
      tick_o <= 1'b0;
    end else begin
      tick_o <= tick_q;
      if (tick_q) begin
        sum_diff_mag_o <= res_used ? mags[3] : phase_sum_mag_i;
        sum_diff_ang_o <= ANG_W'(phase_sum_ang_i - res_ang);
      end
    end
  end

endmodule
`default_nettype wire

/* File: dv/ct_supervision_props.sv */
// Checker for the supervision block, bound to its top module.
// Assumes one clock domain; status outputs judged against the sequence only while forcing is off, forced values when on.
`default_nettype none
module ct_supervision_props
  import ct_supervision_pkg::*;
#(
  parameter int TICK_LEN = TICK_CYCLES
) (
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  input wire logic [DLY_W-1:0] alarm_delay_i,
  input wire logic force_enable_i,
  input wire logic [1:0] force_status_i,
  input wire logic start_o,
  input wire logic blocked_o,
  input wire logic alarm_o,
  input wire logic [MAG_W-1:0] sum_diff_mag_o,
  input wire logic tick_o
);
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!rst_b_i);
  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  int gap_q;
  int run_q;
  logic [1:0] frc_q;
  logic nf;
  // Outputs lag the force input, so two cycles of history are kept
  assign nf = !force_enable_i && (frc_q == 2'h0);
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      frc_q <= 2'h0;
      gap_q <= -1000000;
      run_q <= 0;
    end else begin
      frc_q <= {frc_q[0], force_enable_i};
      gap_q <= tick_o ? 1 : gap_q + 1;
      run_q <= !start_o ? 0 : run_q + int'(tick_o);
    end
  end
  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  property p_tick_gap;
    tick_o && gap_q > 0 |-> gap_q == TICK_LEN;
  endproperty
  a_tick_gap: assert property (p_tick_gap) else $error("tick spacing wrong");
  property p_outs_on_tick;
    ($changed(start_o) || $changed(blocked_o)) && nf |-> $past(tick_o);
  endproperty
  a_outs_on_tick: assert property (p_outs_on_tick) else $error("status moved off tick");
  property p_start_excl;
    start_o && nf |-> !blocked_o;
  endproperty
  a_start_excl: assert property (p_start_excl) else $error("start with blocked");
  property p_alarm_start;
    alarm_o && nf |-> start_o;
  endproperty
  a_alarm_start: assert property (p_alarm_start) else $error("alarm without start");
  property p_alarm_delay;
    $rose(alarm_o) && nf |-> run_q + 1 >= int'(alarm_delay_i) &&
      run_q <= int'(alarm_delay_i) + 2;
  endproperty
  a_alarm_delay: assert property (p_alarm_delay) else $error("alarm delay wrong");
  property p_force_alarm;
    (force_enable_i && force_status_i == FORCE_ALARM) [*2] |-> alarm_o;
  endproperty
  a_force_alarm: assert property (p_force_alarm) else $error("forced alarm absent");
  property p_force_block;
    (force_enable_i && force_status_i == FORCE_BLOCKED) [*2] |-> blocked_o && !alarm_o;
  endproperty
  a_force_block: assert property (p_force_block) else $error("forced block absent");
  property p_diff_tick;
    $changed(sum_diff_mag_o) |-> ##[0:1] tick_o;
  endproperty
  a_diff_tick: assert property (p_diff_tick) else $error("readout moved off tick");
endmodule
bind current_transformer_supervision ct_supervision_props #(.TICK_LEN(TICK_LEN)) i_props (
  .ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .alarm_delay_i(alarm_delay_i),
  .force_enable_i(force_enable_i), .force_status_i(force_status_i), .start_o(start_o),
  .blocked_o(blocked_o), .alarm_o(alarm_o), .sum_diff_mag_o(sum_diff_mag_o), .tick_o(tick_o)
);
`default_nettype wire

/* File: dv/ct_channel_model.sv */
// Measurement channels and blocking source facing the supervision block.
// Assumes tick_i marks the 5 ms update; values change only there.
`default_nettype none
module ct_channel_model
  import ct_supervision_pkg::*;
#(
  parameter int W = 6 * MAG_W + 1
) (
  input wire logic ref_clk_i,
  input wire logic tick_i,
  input wire logic [W-1:0] next_i,
  output logic [W-1:0] meas_o
);
  timeunit 1ns;
  timeprecision 100ps;
  // ------------------------------------------------------------
  // Refresh
  // ------------------------------------------------------------
  initial meas_o = '0;
  // Blocking held a whole update, so it always lands well before expiry
  always @(posedge ref_clk_i) begin
    if (tick_i === 1'b1) begin
      meas_o <= #1 next_i;
    end
  end
endmodule
`default_nettype wire

/* File: dv/current_transformer_supervision_tb.sv */
// Self-checking bench for the supervision block with a reference model.
// Assumes a shortened tick; the channel model refreshes inputs per tick.
`default_nettype none
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin n_errors++; \
  $display("MISMATCH %s exp %0h got %0h", nm, e, g); end end
module current_transformer_supervision_tb
  import ct_supervision_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int TL = 8;
  localparam int D = 12;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [MAG_W-1:0] hi_lim, lo_lim, rat_lim, unb_lim, sum_lim, smag, res1, res2, diff_mag;
  logic [ANG_W-1:0] sang, ang1, ang2, diff_ang;
  logic [DLY_W-1:0] dly;
  logic [1:0] sel, fst;
  logic sub_sel, fen, start, blocked, alarm, tick;
  logic [6*MAG_W:0] next, meas;
  int n_errors = 0, samples_checked = 0, add_v = 0, sub_v = 0, i, k1, k2;
  integer seed = 32'hcc96c204;
  bit hi_over = 1'b0;
  always #10 clk = ~clk;
  ct_channel_model i_ct_channel_model (.ref_clk_i(clk), .tick_i(tick), .next_i(next),
    .meas_o(meas));
  current_transformer_supervision #(.TICK_LEN(TL)) i_current_transformer_supervision (
    .ref_clk_i(clk), .rst_b_i(rst_b), .phase_a_mag_i(meas[15:0]), .phase_b_mag_i(meas[31:16]),
    .phase_c_mag_i(meas[47:32]), .residual_channel_one_i(res1), .residual_channel_two_i(res2),
    .residual_one_ang_i(ang1), .residual_two_ang_i(ang2), .phase_sum_mag_i(smag),
    .phase_sum_ang_i(sang), .sum_diff_add_i(meas[79:64]), .sum_diff_sub_i(meas[95:80]),
    .sequence_unbalance_ratio_i(meas[63:48]), .block_i(meas[96]), .high_limit_i(hi_lim),
    .phase_current_limit_i(lo_lim), .ratio_limit_i(rat_lim), .unbalance_limit_i(unb_lim),
    .residual_current_limit_i(sum_lim), .alarm_delay_i(dly), .residual_select_i(sel),
    .residual_subtract_i(sub_sel), .force_enable_i(fen), .force_status_i(fst),
    .start_o(start), .blocked_o(blocked), .alarm_o(alarm), .sum_diff_mag_o(diff_mag),
    .sum_diff_ang_o(diff_ang), .tick_o(tick));
  // ------------------------------------------------------------
  // Model and tasks
  // ------------------------------------------------------------
  function automatic logic [6*MAG_W:0] frame(int a, int b, int c, int u, bit blk);
    return {blk, 16'(sub_v), 16'(add_v), 16'(u), 16'(c), 16'(b), 16'(a)};
  endfunction
  // High limit latches until 97 percent; other checks strict, no memory
  function automatic bit m_pick(int a, int b, int c, int u);
    int mx;
    int mn;
    bit res;
    mx = a > b ? (a > c ? a : c) : (b > c ? b : c);
    mn = a < b ? (a < c ? a : c) : (b < c ? b : c);
    if (mx > int'(hi_lim)) hi_over = 1'b1;
    else if (mx * PCT_FULL < int'(hi_lim) * REL_OVER_PCT) hi_over = 1'b0;
    res = sel == RES_ONE || sel == RES_TWO;
    return !hi_over && mx > int'(lo_lim) && mn < int'(lo_lim) &&
      mn * RATIO_FULL < mx * int'(rat_lim) &&
      u > int'(unb_lim) && (!res || (sub_sel ? sub_v : add_v) > int'(sum_lim));
  endfunction
  task automatic wait_ticks(int n);
    int g;
    repeat (n) begin
      g = 0;
      do begin
        @(posedge clk);
        #1;
        g++;
      end while (tick !== 1'b1 && g < 4 * TL);
      if (g >= 4 * TL) n_errors++;
    end
  endtask
  task automatic apply(int a, int b, int c, int u, bit blk);
    bit p;
    @(posedge clk);
    #1 next = frame(a, b, c, u, blk);
    wait_ticks(6);
    p = m_pick(a, b, c, u);
    `CHK("start", p && !blk, start)
    `CHK("blocked", p && blk, blocked)
    `CHK("alarm", 1'b0, alarm)
  endtask
  task automatic time_alarm(int a, int u, output int k);
    apply(100, 100, 100, 0, 0);
    next = frame(a, 100, 100, u, 0);
    k = 0;
    while (start !== 1'b1 && k < 20) begin
      wait_ticks(1);
      k++;
    end
    k = 0;
    while (alarm !== 1'b1 && k < 40) begin
      wait_ticks(1);
      k++;
    end
  endtask
  task automatic end_of_test();
    if (n_errors == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // ------------------------------------------------------------
  // Stimulus
  // ------------------------------------------------------------
  initial begin
    {hi_lim, lo_lim, rat_lim} = {HIGH_LIMIT_RST, LOW_LIMIT_RST, RATIO_LIMIT_RST};
    {unb_lim, sum_lim, dly} = {UNBAL_LIMIT_RST, SUM_LIMIT_RST, 19'(D)};
    {sel, fst, sub_sel, fen} = {RES_NONE, FORCE_NORMAL, 2'h0};
    {res1, res2, smag} = 48'({$random(seed), $random(seed)});
    {sang, ang1, ang2} = 48'({$random(seed), $random(seed)});
    next = frame(100, 100, 100, 0, 0);
    repeat (12) @(posedge clk);
    #1 rst_b = 1'b1;
    `CHK("reset", 3'h0, {start, blocked, alarm})
    for (i = 0; i < 4; i++) begin
      apply(90 + {$random(seed)} % 20, 90 + {$random(seed)} % 20, 100, {$random(seed)} % 4900, 0);
    end
    for (i = 0; i < 3; i++) begin
      apply(i == 0 ? 9 : 100, i == 1 ? 9 : 100, i == 2 ? 9 : 100, 5000, 0);
      apply(100, 100, 100, 0, 0);
    end
    apply(0, 5, 5, 5000, 0);
    apply(0, 100, 100, 4900, 0);
    apply(0, 100, 100, 4901, 0);
    unb_lim = 16'd4000;
    apply(0, 100, 100, 4500, 0);
    unb_lim = UNBAL_LIMIT_RST;
    apply(0, 130, 100, 5000, 0);
    apply(0, 118, 100, 5000, 0);
    apply(0, 115, 100, 5000, 0);
    apply(0, 100, 100, 5000, 1);
    apply(100, 100, 100, 0, 0);
    apply(0, 100, 100, 5000, 1);
    apply(0, 100, 100, 5000, 0);
    sub_v = 80;
    for (i = 1; i < 3; i++) begin
      sel = 2'(i);
      sub_sel = 1'b0;
      apply(0, 100, 100, 5000, 0);
      `CHK("diff_mag", 16'h0, diff_mag)
      sub_sel = 1'b1;
      apply(0, 100, 100, 5000, 0);
      `CHK("diff_mag", 16'h50, diff_mag)
      `CHK("diff_ang", 16'(sang - (i == 1 ? ang1 : ang2)), diff_ang)
    end
    sel = 2'h3;
    apply(0, 100, 100, 5000, 0);
    sel = RES_NONE;
    apply(100, 100, 100, 0, 0);
    for (i = 0; i < 3; i++) begin
      fst = 2'(i);
      fen = 1'b1;
      repeat (3) @(posedge clk);
      #1;
      `CHK("forced_alarm", i == 1, alarm)
      `CHK("forced_block", i == 2, blocked)
    end
    fen = 1'b0;
    time_alarm(0, 5000, k1);
    `CHK("alarm_delay", 1'b1, k1 >= D - 1 && k1 <= D + 2)
    time_alarm(9, 9000, k2);
    `CHK("alarm_delay", k1, k2)
    end_of_test();
  end
  // Roughly twice the expected number of ticks
  initial begin
    #(400 * TL * 20);
    n_errors++;
    end_of_test();
  end
endmodule
`default_nettype wire
